// File: rtl/pg_pkg.sv
package pg_pkg;
	// ==========================================
	// register map
	localparam logic [7:0] PG_ADDR_DIR_CONFIG = 8'haf;
	localparam logic [7:0] PG_ADDR_PIN_INPUT = 8'hcf;
	localparam logic [7:0] PG_ADDR_PIN_OUTPUT = 8'hef;
	localparam logic [7:0] PG_DIR_CONFIG_RESET = 8'h00;
	localparam logic [7:0] PG_PIN_INPUT_RESET = 8'hff;
	localparam logic [7:0] PG_PIN_OUTPUT_RESET = 8'h00;
	localparam logic [7:0] PG_UNMAPPED_READ = 8'h00;
	// ==========================================
	// alternate-function pin positions
	localparam int PG_PIN_INT = 6;
	localparam int PG_PIN_WRH = 7;
	// ==========================================
	// host interface modes
	localparam logic [1:0] PG_MODE_MUX8 = 2'h0;
	localparam logic [1:0] PG_MODE_MUX16 = 2'h1;
	// ==========================================
	// bus timing: ready held low this long after each strobe
	localparam int PG_CLK_PERIOD_PS = 4000;
	localparam int PG_WAIT_TIME_PS = 8000;
	localparam int PG_WAIT_CYCLES = (PG_WAIT_TIME_PS + PG_CLK_PERIOD_PS - 1) / PG_CLK_PERIOD_PS;
	// ==========================================
	// bus cycle state
	typedef enum logic [0:0] {
		PG_BUS_IDLE = 1'b0,
		PG_BUS_WAIT = 1'b1
	} pg_bus_state_type;
endpackage

// File: rtl/pg_sync.sv
`timescale 1ns/1ps
// ==========================================
// two-stage synchroniser, one per bit
module pg_sync #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_reg <= RESET_VALUE;
			sync_reg <= RESET_VALUE;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// File: rtl/pg_port.sv
`timescale 1ns/1ps
module pg_port
	import pg_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int WAIT_CYCLES = PG_WAIT_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] host_mode,
	input wire logic cs_n,
	input wire logic [7:0] address,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [WIDTH-1:0] data_in,
	output logic [WIDTH-1:0] data_out,
	output logic data_oe,
	output logic ready_out,
	output logic ready_oe,
	input wire logic int_alt_en,
	input wire logic int_request,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] pin_pullup
);
	// ==========================================
	// elaboration checks
	generate
		if (WIDTH != 8) begin : g_bad_width
			$error("pg_port supports an eight-bit port only");
		end
		if (WAIT_CYCLES < 1 || WAIT_CYCLES > 255) begin : g_bad_wait
			$error("pg_port wait count must be 1 to 255");
		end
	endgenerate

	localparam logic [7:0] WAIT_LAST = 8'(WAIT_CYCLES - 1);

	// ==========================================
	// registers
	logic [WIDTH-1:0] dir_config_reg;
	logic [WIDTH-1:0] pin_output_reg;
	logic configured_reg;
	logic rd_n_prev_reg;
	logic wr_n_prev_reg;
	pg_bus_state_type state_reg;
	pg_bus_state_type state_next;
	logic [7:0] wait_count_reg;
	logic [7:0] wait_count_next;
	logic [WIDTH-1:0] data_out_reg;
	logic data_oe_reg;
	logic ready_oe_reg;
	logic [WIDTH-1:0] pin_out_reg;
	logic [WIDTH-1:0] pin_oe_reg;
	logic [WIDTH-1:0] pin_pullup_reg;
	logic [WIDTH-1:0] pin_sync;

	// ==========================================
	// pin input synchronisation
	pg_sync #(
		.WIDTH(WIDTH),
		.RESET_VALUE(PG_PIN_INPUT_RESET)
	) u_pin_sync (
		.clock(clock),
		.rst(rst),
		.async_in(pin_in),
		.sync_out(pin_sync)
	);

	// ==========================================
	// bus decode
	wire bus_mode_ok = (host_mode == PG_MODE_MUX8) || (host_mode == PG_MODE_MUX16);
	wire selected = bus_mode_ok && !cs_n;
	wire rd_start = selected && !rd_n && rd_n_prev_reg;
	wire wr_start = selected && !wr_n && wr_n_prev_reg;
	wire rd_active = selected && !rd_n;
	wire hit_dir = address == PG_ADDR_DIR_CONFIG;
	wire hit_in = address == PG_ADDR_PIN_INPUT;
	wire hit_out = address == PG_ADDR_PIN_OUTPUT;
	wire wr_dir = wr_start && hit_dir;
	wire wr_out = wr_start && hit_out;

	// read data selection; unmapped addresses return zero
	wire [WIDTH-1:0] read_mux =
		hit_dir ? dir_config_reg :
		hit_in ? pin_sync :
		hit_out ? pin_output_reg :
		PG_UNMAPPED_READ;

	// ==========================================
	// pin drive selection
	wire pin7_alt = host_mode == PG_MODE_MUX16;
	wire pin6_alt = int_alt_en;
	logic [WIDTH-1:0] pin_out_next;
	logic [WIDTH-1:0] pin_oe_next;
	logic [WIDTH-1:0] pin_pullup_next;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			// alternate functions override the register-driven enable, the interrupt pin its level too; pull-ups still follow configured_reg
			wire is_int = (i == PG_PIN_INT) && pin6_alt;
			wire is_wrh = (i == PG_PIN_WRH) && pin7_alt;
			// interrupt is open drain: drive low only while requested
			assign pin_out_next[i] = is_int ? 1'b0 : pin_output_reg[i];
			assign pin_oe_next[i] = is_int ? int_request :
				is_wrh ? 1'b0 :
				(configured_reg && dir_config_reg[i]);
			assign pin_pullup_next[i] = !configured_reg;
		end
	endgenerate

	// ==========================================
	// configuration registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			dir_config_reg <= PG_DIR_CONFIG_RESET;
			pin_output_reg <= PG_PIN_OUTPUT_RESET;
			configured_reg <= 1'b0;
		end else begin
			if (wr_dir) begin
				dir_config_reg <= data_in;
				configured_reg <= 1'b1;
			end
			if (wr_out) begin
				pin_output_reg <= data_in;
			end
		end
	end

	// ==========================================
	// strobe history for edge detection
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_n_prev_reg <= 1'b1;
			wr_n_prev_reg <= 1'b1;
		end else begin
			rd_n_prev_reg <= rd_n;
			wr_n_prev_reg <= wr_n;
		end
	end

	// ==========================================
	// ready sequencing: hold ready low for a fixed wait after each strobe
	always_comb begin
		state_next = state_reg;
		wait_count_next = wait_count_reg;
		unique case (state_reg)
			PG_BUS_IDLE: begin
				if (rd_start || wr_start) begin
					state_next = PG_BUS_WAIT;
					wait_count_next = 8'h00;
				end
			end
			PG_BUS_WAIT: begin
				if (wait_count_reg == WAIT_LAST) begin
					state_next = PG_BUS_IDLE;
				end else begin
					wait_count_next = wait_count_reg + 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= PG_BUS_IDLE;
			wait_count_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			wait_count_reg <= wait_count_next;
		end
	end

	// ==========================================
	// output flops; ready pulls low only, the board pull-up gives the high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ready_oe_reg <= 1'b0;
			data_out_reg <= '0;
			data_oe_reg <= 1'b0;
			pin_out_reg <= PG_PIN_OUTPUT_RESET;
			pin_oe_reg <= '0;
			pin_pullup_reg <= '1;
		end else begin
			ready_oe_reg <= bus_mode_ok && (state_next == PG_BUS_WAIT);
			data_out_reg <= read_mux;
			data_oe_reg <= rd_active;
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
			pin_pullup_reg <= pin_pullup_next;
		end
	end

	assign data_out = data_out_reg;
	assign data_oe = data_oe_reg;
	assign ready_out = 1'b0 & ready_oe_reg;
	assign ready_oe = ready_oe_reg;
	assign pin_out = pin_out_reg;
	assign pin_oe = pin_oe_reg;
	assign pin_pullup = pin_pullup_reg;
endmodule

// File: tb/pg_port_properties.sv
`timescale 1ns/1ps
// ==========================================
// bus and pin relations at the port edge
module pg_port_properties (
	input wire logic clock,
	input wire logic rst,
	input wire logic [1:0] host_mode,
	input wire logic cs_n,
	input wire logic [7:0] address,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [7:0] data_in,
	input wire logic data_oe,
	input wire logic ready_out,
	input wire logic ready_oe,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// a live cycle needs mode 0 or 1 and the chip selected
	wire sel = host_mode < 2'h2 && !cs_n;
	wire idle = rd_n & wr_n;
	wire wr0 = host_mode == 2'h0 && !cs_n;
	AST_RD_OE: assert property (sel && !rd_n |=> data_oe)
		else $error("read data not driven");
	AST_RD_OFF: assert property (!sel || rd_n |=> !data_oe)
		else $error("data bus driven outside a read");
	AST_RDY_LEN: assert property (sel && $fell(idle) |=> ready_oe[*2] ##1 !ready_oe)
		else $error("wait length wrong");
	AST_RDY_CAUSE: assert property ($rose(ready_oe) |-> $past(sel) && !$past(idle))
		else $error("wait without a strobe");
	AST_DRAIN: assert property (ready_out == 1'b0)
		else $error("ready driven high");
	AST_PULLUP: assert property (pin_pullup == 8'hff ? pin_oe == 8'h00 : pin_pullup == 8'h00)
		else $error("pull-up and driver mixed");
	AST_DIR: assert property (wr0 && address == 8'haf && $fell(wr_n)
		|-> ##2 pin_oe == $past(data_in, 2))
		else $error("direction not applied");
	AST_OUT: assert property (wr0 && address == 8'hef && $fell(wr_n)
		|-> ##2 pin_out == $past(data_in, 2))
		else $error("output level not applied");
endmodule

// File: tb/pg_pins_model.sv
`timescale 1ns/1ps
// ==========================================
// board logic on the port pins
module pg_pins_model (
	input wire logic clock,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] pin_pullup,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin_in
);
	logic [7:0] float_reg = 8'h00;
	// a floating pin wanders, so a stale level never reads as a match
	always_ff @(posedge clock) begin
		float_reg <= ~float_reg;
	end
	// port driver wins, then board driver, then pull-up, else floating
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup | float_reg));
endmodule

// File: tb/pg_port_bench.sv
`timescale 1ns/1ps
module pg_port_bench;
	import pg_pkg::*;
	logic clock = 0, rst = 1, cs_n = 1, rd_n = 1, wr_n = 1, data_oe, ready_out, ready_oe;
	logic int_alt_en = 0, int_request = 0;
	logic [1:0] host_mode = 2'h0;
	logic [7:0] address = 8'h00, data_in = 8'h00, ext_en = 8'h00, ext_val = 8'h00, rdata;
	logic [7:0] data_out, pin_in, pin_out, pin_oe, pin_pullup;
	int errors = 0, samples_checked = 0, cycles = 0;
	// ==========================================
	// design, board and clock
	pg_port dut (.clock(clock), .rst(rst), .host_mode(host_mode), .cs_n(cs_n),
		.address(address), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .data_out(data_out),
		.data_oe(data_oe), .ready_out(ready_out), .ready_oe(ready_oe), .int_alt_en(int_alt_en),
		.int_request(int_request), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup));
	pg_pins_model board (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	initial forever #2 clock = ~clock;
	// the whole run needs well under a hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end
	// ==========================================
	// helpers
	task conclude;
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one host access; strobe held until ready is released again
	task access(input logic rd, input logic [7:0] addr, input logic [7:0] wdata);
		int n;
		@(negedge clock);
		cs_n = 0;
		address = addr;
		data_in = wdata;
		rd_n = !rd;
		wr_n = rd;
		for (n = 0; n < 8 && ready_oe !== 1'b1; n++) @(negedge clock);
		for (n = 0; n < 8 && ready_oe === 1'b1; n++) @(negedge clock);
		chk("wait length", 8'(PG_WAIT_CYCLES), 8'(n));
		rdata = data_out;
		cs_n = 1;
		rd_n = 1;
		wr_n = 1;
	endtask
	// ==========================================
	// scenarios
	task t_reset;
		access(1, PG_ADDR_DIR_CONFIG, 0); chk("direction", 8'h00, rdata);
		access(1, PG_ADDR_PIN_OUTPUT, 0); chk("output reg", 8'h00, rdata);
		access(1, PG_ADDR_PIN_INPUT, 0); chk("input reg", 8'hff, rdata);
		chk("pull-ups", 8'hff, pin_pullup);
		chk("pin enables", 8'h00, pin_oe);
	endtask
	task t_config;
		access(0, PG_ADDR_DIR_CONFIG, 8'ha5);
		chk("pin enables", 8'ha5, pin_oe);
		chk("pull-ups", 8'h00, pin_pullup);
		access(0, PG_ADDR_PIN_OUTPUT, 8'h3c);
		chk("pin levels", 8'h3c, pin_out);
		ext_en = 8'h5a;
		ext_val = 8'hff;
		access(1, PG_ADDR_PIN_INPUT, 0); chk("input reg", 8'h7e, rdata);
		access(1, 8'h10, 0); chk("unmapped", PG_UNMAPPED_READ, rdata);
	endtask
	// pin 6 as open-drain interrupt; a register high on that pin must not leak out
	task t_int;
		access(0, PG_ADDR_PIN_OUTPUT, 8'h7c);
		int_alt_en = 1;
		int_request = 1;
		@(negedge clock);
		chk("interrupt level", 8'h3c, pin_out);
		chk("interrupt drive", 8'he5, pin_oe);
		int_request = 0;
		@(negedge clock);
		chk("interrupt released", 8'ha5, pin_oe);
		int_alt_en = 0;
		@(negedge clock);
		chk("pin levels", 8'h7c, pin_out);
	endtask
	// a reset in mid-run must bring back the register, pull-up and pin-enable reset values
	task t_rerun;
		@(negedge clock);
		rst = 1;
		repeat (2) @(negedge clock);
		rst = 0;
		t_reset();
	endtask
	// mode 1 answers like mode 0; mode 2 leaves the bus alone
	task t_modes;
		host_mode = PG_MODE_MUX16;
		access(1, PG_ADDR_PIN_OUTPUT, 0); chk("mode 1 read", 8'h7c, rdata);
		chk("pin 7 released", 8'h25, pin_oe);
		@(negedge clock);
		host_mode = 2'h2;
		cs_n = 0;
		rd_n = 0;
		repeat (3) @(negedge clock);
		chk("mode 2 bus", 8'h00, {6'h00, data_oe, ready_oe});
		cs_n = 1;
		rd_n = 1;
		host_mode = PG_MODE_MUX8;
	endtask
	initial begin
		repeat (4) @(negedge clock);
		rst = 0;
		t_reset();
		t_config();
		t_int();
		t_modes();
		t_rerun();
		conclude();
	end
endmodule
bind pg_port pg_port_properties chk_i (.clock(clock), .rst(rst), .host_mode(host_mode),
	.cs_n(cs_n), .address(address), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in),
	.data_oe(data_oe), .ready_out(ready_out), .ready_oe(ready_oe), .pin_out(pin_out),
	.pin_oe(pin_oe), .pin_pullup(pin_pullup));
